// *** rtl/sof_pkg.sv ***
// Package for the sample output formatter: register map, fields, codes and limits
package sof_pkg;
   // ==========================================
   // Register offsets (word index on the plain port)
   localparam logic [3:0] SOF_REG_CTRL = 4'h0;
   localparam logic [3:0] SOF_REG_BLOCK = 4'h1;
   localparam logic [3:0] SOF_REG_XFER = 4'h2;
   localparam logic [3:0] SOF_REG_STATUS = 4'h3;
   localparam logic [3:0] SOF_REG_READ = 4'h4;
   localparam logic [3:0] SOF_REG_CMD = 4'h5;
   localparam logic [3:0] SOF_REG_COUNT = 4'h6;

   // ==========================================
   // Control field positions
   localparam int SOF_CTL_MODE = 0;
   localparam int SOF_CTL_PORT_LO = 1;
   localparam int SOF_CTL_PORT_HI = 2;
   localparam int SOF_CTL_RES = 3;
   localparam int SOF_CTL_CPLX = 4;
   localparam int SOF_CTL_MIRROR = 5;

   // Command bits
   localparam int SOF_CMD_ARM = 0;
   localparam int SOF_CMD_TRIG = 1;
   localparam int SOF_CMD_CLR = 2;

   // Status bit positions
   localparam int SOF_ST_RUN = 0;
   localparam int SOF_ST_ARMED = 1;
   localparam int SOF_ST_DONE = 2;
   localparam int SOF_ST_OVF = 3;
   localparam int SOF_ST_XFERR = 4;
   localparam int SOF_ST_PART = 5;
   localparam int SOF_ST_SETUP = 6;

   // ==========================================
   // Reset values and limits
   localparam logic [5:0] SOF_CTRL_RST = 6'h00;
   localparam logic [23:0] SOF_BLOCK_RST = 24'h000400;
   localparam logic [23:0] SOF_BLOCK_MIN = 24'h000002;
   localparam logic [23:0] SOF_XFER_RST = 24'h000000;

   // ==========================================
   // Encodings
   typedef enum logic [1:0] {
      SOF_PORT_REG = 2'h0,
      SOF_PORT_BYTE = 2'h1,
      SOF_PORT_OPT = 2'h2
   } sof_port_e;

   typedef enum logic [3:0] {
      SOF_ST_IDLE = 4'h1,
      SOF_ST_WAIT = 4'h2,
      SOF_ST_COLLECT = 4'h4,
      SOF_ST_HALT = 4'h8
   } sof_state_e;

   // Incoming sample: real and imaginary parts, 24 bits each, MSB-aligned for 12-bit
   typedef struct packed {
      logic [23:0] re;
      logic [23:0] im;
   } sof_sample_s;

   typedef struct packed {
      logic [1:0] port;
      logic res24;
      logic cplx;
      logic mirror;
      logic gapless;
   } sof_cfg_s;
endpackage : sof_pkg

// *** rtl/sof_formatter.sv ***
// Sample output formatter: packs samples for register, neighbour-byte and optical ports
`timescale 1ns/100ps
// Contract
// - Block mode halts measurement after one full block is collected.
// - Next block needs new arm then trigger; controller supplies both each block.
// - Continuous mode: one arm plus trigger yields blocks back to back.
// - Register-read port delivers 16-bit words; selected after reset.
// - Byte port sends 8-bit stream to right neighbour, which must accept it.
// - Optical port sends samples as 32-bit words.
// - Resolution selectable between 12 and 24 bits.
// - 12-bit padded with 4 zeros, 24-bit with 8 zeros, MSB first.
// - Complex: real part then imaginary part, before next sample.
// - 24-bit on 16-bit port: bits 23..8 then bits 7..0 plus zeros.
// - 12-bit on byte port: bits 11..4, then bits 3..0 plus zeros.
// - Optical: two real 12-bit per word; 24-bit one word per part.
// - Memory write rate limited: 12-bit each clock, 24-bit every two.
// - Continuous only when rate fits port; optical 250 or 106 MB/s.
// - Mirrored order flips spectrum; upright keeps orientation.
// - Baseband accepts orientation setting but keeps and reports upright.
// - Block may be read in pieces of programmed byte size.
// - Error flagged when piece size does not divide block size.
// - Block size change resets piece size; pieces ignore optical output.
// - Out-of-range block size keeps previous value, sets status bit 6.
module sof_formatter
   import sof_pkg::*;
#(
   parameter int BLK_W = 24,
   parameter logic [BLK_W-1:0] BLOCK_MAX = 24'hC00000
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic baseband_in,
   input wire sof_sample_s samp_in,
   input wire logic samp_valid_in,
   output logic samp_ready_out,
   input wire logic fifo_ovf_in,
   output logic [7:0] byte_data_out,
   output logic byte_valid_out,
   input wire logic byte_ready_in,
   output logic [31:0] opt_data_out,
   output logic opt_valid_out,
   input wire logic opt_ready_in
);
   // ==========================================
   // Configuration
   sof_cfg_s cfg_r;
   logic [BLK_W-1:0] block_r;
   logic [BLK_W-1:0] xfer_r;
   logic setup_err_r;
   logic xfer_err_r;
   logic ovf_r;
   logic done_r;
   logic cfg_wr;
   logic blk_wr;
   logic xfr_wr;
   logic cmd_wr;
   logic reg_pop;
   logic [BLK_W-1:0] blk_new;

   // A data read pops one word; nothing ready reads as zero
   assign cfg_wr = ce_in && wr_in && addr_in == SOF_REG_CTRL;
   assign blk_wr = ce_in && wr_in && addr_in == SOF_REG_BLOCK;
   assign xfr_wr = ce_in && wr_in && addr_in == SOF_REG_XFER;
   assign cmd_wr = ce_in && wr_in && addr_in == SOF_REG_CMD;
   assign reg_pop = ce_in && rd_in && addr_in == SOF_REG_READ;
   assign blk_new = wdata_in[BLK_W-1:0];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_r <= sof_cfg_s'(SOF_CTRL_RST);
      end else if (cfg_wr) begin
         cfg_r.gapless <= wdata_in[SOF_CTL_MODE];
         cfg_r.port <= wdata_in[SOF_CTL_PORT_HI:SOF_CTL_PORT_LO] == 2'h3 ?
            2'(SOF_PORT_REG) : wdata_in[SOF_CTL_PORT_HI:SOF_CTL_PORT_LO];
         cfg_r.res24 <= wdata_in[SOF_CTL_RES];
         cfg_r.cplx <= wdata_in[SOF_CTL_CPLX];
         cfg_r.mirror <= wdata_in[SOF_CTL_MIRROR] && !baseband_in;
      end else if (ce_in && baseband_in) begin
         // Baseband forces upright even if set before the switch
         cfg_r.mirror <= 1'b0;
      end
   end

   // Block size and piece size
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         block_r <= BLK_W'(SOF_BLOCK_RST);
         xfer_r <= BLK_W'(SOF_XFER_RST);
         setup_err_r <= 1'b0;
      end else if (blk_wr) begin
         if (blk_new < SOF_BLOCK_MIN || blk_new > BLOCK_MAX || blk_new[0]) begin
            setup_err_r <= 1'b1;
         end else begin
            block_r <= blk_new;
            xfer_r <= BLK_W'(SOF_XFER_RST);
         end
      end else if (xfr_wr) begin
         xfer_r <= wdata_in[BLK_W-1:0];
      end else if (cmd_wr && wdata_in[SOF_CMD_CLR]) begin
         setup_err_r <= 1'b0;
      end
   end

   // Bytes per sample point: 2, 4 or 8
   function automatic logic [3:0] bytes_per_point(input sof_cfg_s c);
      logic [3:0] b;
      b = c.res24 ? 4'h4 : 4'h2;
      return c.cplx ? 4'(b << 1) : b;
   endfunction : bytes_per_point

   logic [BLK_W+3:0] block_bytes;
   assign block_bytes = (BLK_W+4)'(block_r) * (BLK_W+4)'(bytes_per_point(cfg_r));

   // Rechecked every cycle so a later format change re-flags it
   // piece must divide block
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         xfer_err_r <= 1'b0;
      end else if (ce_in) begin
         xfer_err_r <= xfer_r != '0 && (block_bytes % (BLK_W+4)'(xfer_r)) != '0;
      end
   end

   // ==========================================
   // Acquisition control
   sof_state_e st_r;
   logic [BLK_W-1:0] pts_r;
   logic take;
   logic last_pt;
   logic arm_cmd;
   logic trig_cmd;

   assign arm_cmd = cmd_wr && wdata_in[SOF_CMD_ARM];
   assign trig_cmd = cmd_wr && wdata_in[SOF_CMD_TRIG];
   assign last_pt = pts_r == block_r - BLK_W'(1);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_r <= SOF_ST_IDLE;
      end else if (ce_in) begin
         unique case (st_r)
            SOF_ST_IDLE, SOF_ST_HALT: begin
               if (arm_cmd) begin
                  st_r <= SOF_ST_WAIT;
               end
            end
            SOF_ST_WAIT: begin
               if (trig_cmd) begin
                  st_r <= SOF_ST_COLLECT;
               end
            end
            SOF_ST_COLLECT: begin
               // Overflow halts either mode; recovery needs a fresh arm
               // overflow ends run
               if (fifo_ovf_in) begin
                  st_r <= SOF_ST_HALT;
               end else if (take && last_pt && !cfg_r.gapless) begin
                  st_r <= SOF_ST_HALT;
               end
            end
            default: st_r <= SOF_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || (ce_in && trig_cmd)) begin
         pts_r <= '0;
      end else if (ce_in && take) begin
         pts_r <= last_pt ? '0 : pts_r + BLK_W'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ovf_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce_in) begin
         if (st_r == SOF_ST_COLLECT && fifo_ovf_in) begin
            ovf_r <= 1'b1;
         end else if (cmd_wr && wdata_in[SOF_CMD_CLR]) begin
            ovf_r <= 1'b0;
         end
         if (take && last_pt) begin
            done_r <= 1'b1;
         end else if (arm_cmd) begin
            done_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // Serializer: one sample point loaded as up to 64 bits, shifted out MSB first
   logic [63:0] sh_r;
   logic [3:0] left_r;
   logic [3:0] unit_bytes;
   logic [23:0] im_sel;
   logic [31:0] re_slot;
   logic [31:0] im_slot;
   logic pair_r;
   logic [15:0] pair_hold_r;
   logic emit;
   logic sink_ready;
   logic [31:0] rd_word_r;
   logic [1:0] rate_r;

   // Most negative value maps to itself, a one-code limitation
   // mirror by conjugation
   assign im_sel = cfg_r.mirror ? 24'(-samp_in.im) : samp_in.im;
   assign re_slot = cfg_r.res24 ? {samp_in.re, 8'h00} : {samp_in.re[23:12], 4'h0, 16'h0000};
   assign im_slot = cfg_r.res24 ? {im_sel, 8'h00} : {im_sel[23:12], 4'h0, 16'h0000};

   always_comb begin
      unique case (cfg_r.port)
         2'(SOF_PORT_BYTE): unit_bytes = 4'h1;
         2'(SOF_PORT_OPT): unit_bytes = 4'h4;
         default: unit_bytes = 4'h2;
      endcase
   end

   // Stream ports take a new unit when the output is empty or as the old one leaves
   // port pace bounds stream
   always_comb begin
      unique case (cfg_r.port)
         2'(SOF_PORT_BYTE): sink_ready = byte_ready_in || !byte_valid_out;
         2'(SOF_PORT_OPT): sink_ready = opt_ready_in || !opt_valid_out;
         default: sink_ready = reg_pop;
      endcase
   end

   // Free-running phase: a 24-bit point may wait one extra clock
   // 24-bit every second clock
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rate_r <= 2'h0;
      end else if (ce_in) begin
         rate_r <= rate_r == 2'h1 ? 2'h0 : rate_r + 2'h1;
      end
   end

   assign take = ce_in && left_r == 4'h0 && samp_valid_in && st_r == SOF_ST_COLLECT
      && (!cfg_r.res24 || rate_r == 2'h0);
   assign samp_ready_out = take;
   assign emit = ce_in && left_r != 4'h0 && sink_ready;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sh_r <= '0;
         left_r <= 4'h0;
      end else if (take) begin
         if (cfg_r.res24) begin
            sh_r <= cfg_r.cplx ? {re_slot, im_slot} : {re_slot, 32'h00000000};
            left_r <= bytes_per_point(cfg_r);
         end else begin
            sh_r <= cfg_r.cplx ? {re_slot[31:16], im_slot[31:16], 32'h00000000}
               : {re_slot[31:16], 48'h000000000000};
            left_r <= bytes_per_point(cfg_r);
         end
      end else if (emit) begin
         sh_r <= sh_r << {unit_bytes, 3'h0};
         left_r <= left_r > unit_bytes ? left_r - unit_bytes : 4'h0;
      end
   end

   // Arm drops a held half so a new run never pairs stale data
   // hold half-word
   logic opt_half;
   assign opt_half = cfg_r.port == 2'(SOF_PORT_OPT) && !cfg_r.res24 && !cfg_r.cplx;

   always_ff @(posedge clk_in) begin
      if (rst_in || (ce_in && arm_cmd)) begin
         pair_r <= 1'b0;
         pair_hold_r <= 16'h0000;
      end else if (emit && opt_half) begin
         pair_r <= !pair_r;
         pair_hold_r <= sh_r[63:48];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         opt_valid_out <= 1'b0;
         opt_data_out <= 32'h00000000;
      end else if (ce_in) begin
         if (emit && cfg_r.port == 2'(SOF_PORT_OPT) && (!opt_half || pair_r)) begin
            opt_valid_out <= 1'b1;
            opt_data_out <= opt_half ? {pair_hold_r, sh_r[63:48]} : sh_r[63:32];
         end else if (opt_ready_in) begin
            opt_valid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         byte_valid_out <= 1'b0;
         byte_data_out <= 8'h00;
      end else if (ce_in) begin
         if (emit && cfg_r.port == 2'(SOF_PORT_BYTE)) begin
            byte_valid_out <= 1'b1;
            byte_data_out <= sh_r[63:56];
         end else if (byte_ready_in) begin
            byte_valid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_word_r <= 32'h00000000;
      end else if (reg_pop) begin
         rd_word_r <= (emit && cfg_r.port == 2'(SOF_PORT_REG)) ?
            {16'h0000, sh_r[63:48]} : 32'h00000000;
      end
   end

   // ==========================================
   // Register read mux, data one cycle after strobe
   // Reads never stall; the slave answers every strobe
   logic [31:0] rd_mux_r;
   logic rd_data_sel_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_mux_r <= 32'h00000000;
         rd_data_sel_r <= 1'b0;
      end else if (ce_in) begin
         rd_data_sel_r <= reg_pop;
         rd_mux_r <= 32'h00000000;
         if (rd_in) begin
            unique case (addr_in)
               SOF_REG_CTRL: rd_mux_r <= 32'({cfg_r.mirror, cfg_r.cplx, cfg_r.res24,
                  cfg_r.port, cfg_r.gapless});
               SOF_REG_BLOCK: rd_mux_r <= 32'(block_r);
               SOF_REG_XFER: rd_mux_r <= 32'(xfer_r);
               SOF_REG_STATUS: rd_mux_r <= 32'({setup_err_r, pair_r, xfer_err_r,
                  ovf_r, done_r, st_r == SOF_ST_WAIT, st_r == SOF_ST_COLLECT});
               SOF_REG_COUNT: rd_mux_r <= 32'(pts_r);
               default: rd_mux_r <= 32'h00000000;
            endcase
         end
      end
   end

   assign rdata_out = rd_data_sel_r ? rd_word_r : rd_mux_r;
endmodule : sof_formatter

// *** dv/sof_sink.sv ***
// Far-side model: byte and optical receivers
`timescale 1ns/100ps
module sof_sink (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] byte_data_in,
   input wire logic byte_valid_in,
   input wire logic [31:0] opt_data_in,
   input wire logic opt_valid_in,
   output logic byte_ready_out,
   output logic opt_ready_out
);
   logic [31:0] got[$];
   int seed = 91;
   initial begin
      byte_ready_out = 1'b0;
      opt_ready_out = 1'b0;
   end
   always @(posedge clk_in) begin
      if (byte_valid_in && byte_ready_out) begin
         got.push_back({24'h0, byte_data_in});
      end
      if (opt_valid_in && opt_ready_out) begin
         got.push_back(opt_data_in);
      end
      byte_ready_out <= !rst_in && (($random(seed) & 3) != 0);
      opt_ready_out <= !rst_in && (($random(seed) & 3) != 0);
   end
endmodule : sof_sink

// *** dv/sof_monitor.sv ***
// Port checker for the sample output formatter
`timescale 1ns/100ps
module sof_monitor
   import sof_pkg::*;
#(
   parameter int BLK_W = 24,
   parameter logic [BLK_W-1:0] BLOCK_MAX = 24'hC00000
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic baseband_in,
   input wire logic samp_valid_in,
   input wire logic samp_ready_out,
   input wire logic [7:0] byte_data_out,
   input wire logic byte_valid_out,
   input wire logic byte_ready_in,
   input wire logic [31:0] opt_data_out,
   input wire logic opt_valid_out,
   input wire logic opt_ready_in
);
   // ==========
   // Helpers
   logic res24_r;
   logic odd_r;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         res24_r <= 1'b0;
      end else if (ce_in && wr_in && addr_in == SOF_REG_CTRL) begin
         res24_r <= wdata_in[SOF_CTL_RES];
      end
   end
   // Phase only valid while runs end on whole points
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         odd_r <= 1'b0;
      end else if (ce_in && byte_valid_out && byte_ready_in) begin
         odd_r <= !odd_r;
      end
   end
   // ==========
   // Assertions
   default clocking mon_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   AST_RST_QUIET: assert property (disable iff (1'b0) rst_in |=>
      !byte_valid_out && !opt_valid_out && rdata_out == 32'h0) else $error("outputs after reset");
   AST_BYTE_HOLD: assert property (byte_valid_out && !byte_ready_in && ce_in |=>
      byte_valid_out && $stable(byte_data_out)) else $error("byte dropped");
   AST_OPT_HOLD: assert property (opt_valid_out && !opt_ready_in && ce_in |=>
      opt_valid_out && $stable(opt_data_out)) else $error("word dropped");
   AST_BYTE_PAD12: assert property (byte_valid_out && odd_r && !res24_r |->
      byte_data_out[3:0] == 4'h0) else $error("byte pad");
   AST_OPT_PAD24: assert property (opt_valid_out && res24_r |->
      opt_data_out[7:0] == 8'h00) else $error("word pad 24");
   AST_OPT_PAD12: assert property (opt_valid_out && !res24_r |->
      opt_data_out[3:0] == 4'h0 && opt_data_out[19:16] == 4'h0) else $error("word pad 12");
   AST_RATE24: assert property (samp_valid_in && samp_ready_out && res24_r && ce_in |=>
      !samp_ready_out) else $error("24-bit rate");
   AST_UPRIGHT: assert property (ce_in && rd_in && addr_in == SOF_REG_CTRL && baseband_in |=>
      !rdata_out[SOF_CTL_MIRROR]) else $error("orientation readback");
   AST_DATA16: assert property (ce_in && rd_in && addr_in == SOF_REG_READ |=>
      rdata_out[31:16] == 16'h0) else $error("data width");
   AST_ONE_PORT: assert property (!(byte_valid_out && opt_valid_out)) else $error("two ports");
   COV_BYTE: cover property (byte_valid_out && byte_ready_in);
   COV_OPT: cover property (opt_valid_out && opt_ready_in);
   COV_S24: cover property (samp_valid_in && samp_ready_out && res24_r);
endmodule : sof_monitor
bind sof_formatter sof_monitor #(.BLK_W(BLK_W), .BLOCK_MAX(BLOCK_MAX)) sof_monitor_inst (
   .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .baseband_in(baseband_in), .samp_valid_in(samp_valid_in),
   .samp_ready_out(samp_ready_out), .byte_data_out(byte_data_out),
   .byte_valid_out(byte_valid_out), .byte_ready_in(byte_ready_in),
   .opt_data_out(opt_data_out), .opt_valid_out(opt_valid_out), .opt_ready_in(opt_ready_in));

// *** dv/tb.sv ***
// Testbench for the sample output formatter
`timescale 1ns/100ps
module tb
   import sof_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic baseband_in = 1'b0;
   logic samp_valid_in = 1'b0;
   logic fifo_ovf_in = 1'b0;
   logic ce_in = 1'b1;
   logic [5:0] cur_mode = 6'h00;
   sof_sample_s samp_in = '0;
   logic [31:0] rdata_out, opt_data_out;
   logic [7:0] byte_data_out;
   logic samp_ready_out, byte_valid_out, byte_ready_in, opt_valid_out, opt_ready_in;
   int seed = 37720;
   int failures = 0;
   int tests_run = 0;
   int half;
   logic [23:0] hold;
   sof_sample_s sent[$];
   logic [31:0] exp_q[$];
   logic [31:0] got[$];
   logic [5:0] modes[8] = '{6'h00, 6'h18, 6'h02, 6'h3A, 6'h04, 6'h14, 6'h0C, 6'h1C};
   always #5 clk_in = ~clk_in;
   sof_formatter sof_formatter_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .baseband_in(baseband_in), .samp_in(samp_in),
      .samp_valid_in(samp_valid_in), .samp_ready_out(samp_ready_out),
      .fifo_ovf_in(fifo_ovf_in), .byte_data_out(byte_data_out),
      .byte_valid_out(byte_valid_out), .byte_ready_in(byte_ready_in),
      .opt_data_out(opt_data_out), .opt_valid_out(opt_valid_out), .opt_ready_in(opt_ready_in));
   sof_sink sof_sink_inst (.clk_in(clk_in), .rst_in(rst_in), .byte_data_in(byte_data_out),
      .byte_valid_in(byte_valid_out), .opt_data_in(opt_data_out), .opt_valid_in(opt_valid_out),
      .byte_ready_out(byte_ready_in), .opt_ready_out(opt_ready_in));
   // ==========
   // Stimulus and expectations
   // Forced end bits keep every unmirrored register-port word non-zero
   function automatic sof_sample_s new_samp();
      new_samp.re = 24'($random(seed)) | 24'h800001;
      new_samp.im = 24'($random(seed)) | 24'h800001;
   endfunction : new_samp
   always @(posedge clk_in) begin
      if (samp_valid_in && samp_ready_out) begin
         sent.push_back(samp_in);
         samp_in <= new_samp();
      end
      if (!samp_valid_in || samp_ready_out) begin
         samp_valid_in <= !rst_in && (!(cur_mode[4] && cur_mode[2]) || ($random(seed) & 1) == 1);
      end
   end
   function automatic void put(input logic [1:0] p, input logic r24, input logic [23:0] v);
      if (p == 2'h0) begin
         exp_q.push_back(r24 ? {16'h0, v[23:8]} : {16'h0, v[23:12], 4'h0});
         if (r24) begin
            exp_q.push_back({16'h0, v[7:0], 8'h00});
         end
      end else if (p == 2'h1) begin
         exp_q.push_back({24'h0, v[23:16]});
         exp_q.push_back(r24 ? {24'h0, v[15:8]} : {24'h0, v[15:12], 4'h0});
         if (r24) begin
            exp_q.push_back({24'h0, v[7:0]});
            exp_q.push_back(32'h0);
         end
      end else if (r24) begin
         exp_q.push_back({v, 8'h00});
      end else if (half == 0) begin
         hold = v;
         half = 1;
      end else begin
         exp_q.push_back({hold[23:12], 4'h0, v[23:12], 4'h0});
         half = 0;
      end
   endfunction : put
   function automatic void build(input logic [5:0] c, input int n);
      logic [23:0] im;
      exp_q.delete();
      half = 0;
      for (int i = 0; i < n; i++) begin
         im = (c[5] && !baseband_in) ? -sent[i].im : sent[i].im;
         put(c[2:1], c[3], sent[i].re);
         if (c[4]) begin
            put(c[2:1], c[3], im);
         end
      end
   endfunction : build
   // ==========
   // Bus tasks and checks
   task automatic stop_test();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(posedge clk_in);
      d = rdata_out;
   endtask : rd
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk("register", e, d & m);
   endtask : rchk
   task automatic run(input logic [5:0] c, input int blk, input int n);
      logic [31:0] d;
      int cnt;
      int k;
      cnt = n * (c[4] ? 2 : 1) * (c[3] ? 2 : 1) * (c[2:1] == 2'h1 ? 2 : 1) / (c[2] ? 2 : 1);
      cur_mode <= c;
      wr(SOF_REG_CTRL, {26'h0, c});
      wr(SOF_REG_BLOCK, 32'(blk));
      got.delete();
      sof_sink_inst.got.delete();
      sent.delete();
      wr(SOF_REG_CMD, 32'h1);
      wr(SOF_REG_CMD, 32'h2);
      for (k = 0; k < 3000 && got.size() < cnt; k++) begin
         if (c[2:1] == 2'h0) begin
            rd(SOF_REG_READ, d);
            if (d !== 32'h0) begin
               got.push_back(d);
            end
         end else begin
            @(posedge clk_in);
            got = sof_sink_inst.got;
         end
      end
      if (k == 3000) begin
         failures++;
         stop_test();
      end
      repeat (10) @(posedge clk_in);
      build(c, n);
      for (int i = 0; i < cnt; i++) begin
         chk("unit", exp_q[i], got[i]);
      end
   endtask : run
   // ==========
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      samp_in <= new_samp();
      rchk(SOF_REG_CTRL, 32'hFFFFFFFF, 32'h0);
      rchk(SOF_REG_BLOCK, 32'hFFFFFFFF, 32'h400);
      rchk(4'h7, 32'hFFFFFFFF, 32'h0);
      wr(SOF_REG_BLOCK, 32'h1);
      rchk(SOF_REG_BLOCK, 32'hFFFFFFFF, 32'h400);
      rchk(SOF_REG_STATUS, 32'h40, 32'h40);
      wr(SOF_REG_BLOCK, 32'h4);
      wr(SOF_REG_XFER, 32'h3);
      rchk(SOF_REG_STATUS, 32'h10, 32'h10);
      wr(SOF_REG_XFER, 32'h4);
      rchk(SOF_REG_XFER, 32'hFFFFFFFF, 32'h4);
      wr(SOF_REG_BLOCK, 32'h6);
      rchk(SOF_REG_XFER, 32'hFFFFFFFF, 32'h0);
      wr(SOF_REG_CMD, 32'h4);
      rchk(SOF_REG_STATUS, 32'h50, 32'h0);
      baseband_in <= 1'b1;
      wr(SOF_REG_CTRL, 32'h20);
      rchk(SOF_REG_CTRL, 32'h20, 32'h0);
      baseband_in <= 1'b0;
      // Frozen clock enable drops the write
      ce_in <= 1'b0;
      wr(SOF_REG_CTRL, 32'h8);
      ce_in <= 1'b1;
      rchk(SOF_REG_CTRL, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 8; i++) begin
         run(modes[i], 4, 4);
         chk("points", 32'h4, 32'(sent.size()));
         rchk(SOF_REG_STATUS, 32'h5, 32'h4);
         wr(SOF_REG_CMD, 32'h1);
         repeat (20) @(posedge clk_in);
         rchk(SOF_REG_STATUS, 32'h3, 32'h2);
         chk("points", 32'h4, 32'(sent.size()));
      end
      run(6'h03, 4, 12);
      fifo_ovf_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      rchk(SOF_REG_STATUS, 32'h9, 32'h8);
      fifo_ovf_in <= 1'b0;
      wr(SOF_REG_CMD, 32'h4);
      rchk(SOF_REG_STATUS, 32'h8, 32'h0);
      stop_test();
   end
endmodule : tb
